// ===== rtl/scc_pkg.sv
// constants, codes and register map of the scan chain slow clock and driver configuration block
`default_nettype none
package scc_pkg;
    // chain geometry
    localparam int NUM_DESIGNS = 250;          // designs joined in the chain
    localparam int SEL_W = 9;                  // width of the design index
    localparam int BYTE_W = 8;                 // inputs and outputs per design
    localparam int BIT_SHIFT = 3;              // log2 of the bits per design
    localparam int CNT_W = 16;                 // width of the bit counter
    localparam int FIFO_DEPTH = 4;             // words held for software
    localparam int SYNC_STAGES = 2;            // flops on the driver, strobe, select and input pins

    // wait states used when no override is strapped
    localparam logic [7:0] WAIT_DEFAULT = 8'h0A;
    localparam logic [1:0] STRAP_SAMPLE = 2'h2; // cycle after release that samples the strap
    localparam logic [1:0] STRAP_DONE = 2'h3;   // strap window over

    // scan chain driver choice codes
    localparam logic [1:0] DRV_EXT = 2'h0;     // external pins
    localparam logic [1:0] DRV_INT = 2'h1;     // internal controller
    localparam logic [1:0] DRV_LA = 2'h2;      // on-chip analyser
    localparam logic [1:0] DRV_STRAP = 2'h3;   // wait strap code, chain stays on pins

    // register byte addresses on the bus
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_STATUS = 12'h000;
    localparam logic [11:0] ADDR_DIVIDER = 12'h004;
    localparam logic [11:0] ADDR_WAIT = 12'h008;
    localparam logic [11:0] ADDR_OUTDATA = 12'h00C;

    // status register fields
    localparam int STAT_EMPTY = 0;
    localparam int STAT_FULL = 1;
    localparam int STAT_SLOW = 2;
    localparam int STAT_DIVEN = 3;
    localparam int STAT_DRV_LSB = 4;
    localparam int STAT_BUSY = 6;

    // internal controller states
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_SHIFT_IN = 3'h1,
        ST_WAIT_LATCH = 3'h2,
        ST_LATCH = 3'h3,
        ST_WAIT_CAP = 3'h4,
        ST_CAPTURE = 3'h5,
        ST_SHIFT_OUT = 3'h6,
        ST_DONE = 3'h7
    } scc_state_t;
endpackage : scc_pkg
`default_nettype wire

// ===== rtl/scc_top.sv
// slow clock divider, wait states, scan driver selection and internal chain controller
`default_nettype none

// small flop fifo between the controller and software
module scc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem [DEPTH];   // storage flops
    logic [AW-1:0] wr_ptr;           // next slot to fill
    logic [AW-1:0] rd_ptr;           // oldest slot
    logic [AW:0] count;              // words held
    logic push;
    logic pop;

    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // write side stores a word
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers wrap at the depth
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
        end
    end

    // occupancy count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (push && !pop) begin
            count <= count + 1'b1;
        end else if (pop && !push) begin
            count <= count - 1'b1;
        end
    end
endmodule // scc_fifo

module scc_top #(
    parameter int NUM_DESIGNS = scc_pkg::NUM_DESIGNS,
    parameter logic [7:0] WAIT_DEFAULT = scc_pkg::WAIT_DEFAULT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] driver_sel,
    input wire logic set_clk_div,
    input wire logic [8:0] active_select,
    input wire logic [7:0] design_inputs,
    output logic [7:0] design_outputs,
    output logic ready,
    output logic slow_clk,
    output logic first_design_input,
    input wire logic ext_scan_clk_out,
    input wire logic ext_scan_data_out,
    input wire logic ext_scan_select,
    input wire logic ext_scan_latch_en,
    output logic ext_scan_clk_in,
    output logic ext_scan_data_in,
    input wire logic la_scan_clk,
    input wire logic la_scan_data,
    input wire logic la_scan_select,
    input wire logic la_scan_latch_en,
    output logic chain_clk,
    output logic chain_data,
    output logic chain_select,
    output logic chain_latch_en,
    input wire logic chain_ret_clk,
    input wire logic chain_ret_data
);
    localparam int CW = scc_pkg::CNT_W;
    localparam logic [CW-1:0] TOTAL_BITS = CW'(NUM_DESIGNS * scc_pkg::BYTE_W);

    // pin synchronisers: stage 0 feeds stage 1 only
    logic [1:0] drv_m, drv_s;
    logic div_m, div_s;
    logic [8:0] act_m, act_s;
    logic [7:0] in_m, in_s;
    logic div_d;                     // delayed divider enable for edge detect
    logic div_edge;

    // slow clock state
    logic [7:0] factor;              // stored division factor
    logic [7:0] div_cnt;             // refreshes since last toggle

    // wait state configuration
    logic [7:0] wait_cnt;            // wait cycles used by the controller
    logic [1:0] strap_cnt;           // cycles since reset release

    // internal controller
    scc_pkg::scc_state_t state;
    logic [CW-1:0] bit_cnt;          // bits shifted in the current phase
    logic [CW-1:0] out_len;          // bits to shift until the active byte arrives
    logic phase;                     // half of a bit period
    logic [7:0] ws_cnt;              // wait counter
    logic [8:0] act_q;               // design index for this refresh
    logic [7:0] byte_q;              // input byte for this refresh
    logic int_clk, int_data, int_sel, int_latch;
    logic int_data_n;                // falling edge copy of the outgoing data
    logic [7:0] ret_shift;           // bits returned from the chain end

    // fifo and bus
    logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_pop;
    logic [7:0] fifo_out_data;
    logic acc, setup, mapped;

    // bit to present for chain position c of the input shift
    function automatic logic bit_for(input logic [CW-1:0] c, input logic [8:0] act, input logic [7:0] b);
        logic [CW-1:0] r;
        r = TOTAL_BITS - 1'b1 - c;
        return (r[CW-1:scc_pkg::BIT_SHIFT] == CW'(act)) ? b[r[scc_pkg::BIT_SHIFT-1:0]] : 1'b0;
    endfunction

    // two-flop synchronisers for the driver, strobe, select and input pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drv_m <= scc_pkg::DRV_EXT;
            drv_s <= scc_pkg::DRV_EXT;
            div_m <= 1'b0;
            div_s <= 1'b0;
            div_d <= 1'b0;
            act_m <= '0;
            act_s <= '0;
            in_m <= '0;
            in_s <= '0;
        end else begin
            drv_m <= driver_sel;
            drv_s <= drv_m;
            div_m <= set_clk_div;
            div_s <= div_m;
            div_d <= div_s;
            act_m <= active_select;
            act_s <= act_m;
            in_m <= design_inputs;
            in_s <= in_m;
        end
    end
    assign div_edge = div_s && !div_d;

    // division factor taken on the rising edge of the load strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            factor <= '0;
        end else if (div_edge) begin
            factor <= in_s;
        end
    end

    // slow clock advances on refreshes only, off while the strobe is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= '0;
            slow_clk <= 1'b0;
        end else if (!div_s) begin
            div_cnt <= '0;
            slow_clk <= 1'b0;
        end else if (ready) begin
            if (div_cnt == factor) begin
                div_cnt <= '0;
                slow_clk <= !slow_clk;
            end else begin
                div_cnt <= div_cnt + 1'b1;
            end
        end
    end

    // first input bit of the active design carries the slow clock when enabled
    assign first_design_input = div_s ? slow_clk : in_s[0];

    // wait count: default, strapped at release, or written by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_cnt <= WAIT_DEFAULT;
            strap_cnt <= '0;
        end else begin
            if (strap_cnt != scc_pkg::STRAP_DONE) begin
                strap_cnt <= strap_cnt + 1'b1;
            end
            if (strap_cnt == scc_pkg::STRAP_SAMPLE && drv_s == scc_pkg::DRV_STRAP) begin
                wait_cnt <= in_s;
            end else if (acc && pwrite && paddr == scc_pkg::ADDR_WAIT) begin
                wait_cnt <= pwdata[7:0];
            end
        end
    end

    // internal controller: shift in, latch, capture, shift out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= scc_pkg::ST_IDLE;
            bit_cnt <= '0;
            out_len <= '0;
            phase <= 1'b0;
            ws_cnt <= '0;
            act_q <= '0;
            byte_q <= '0;
            int_clk <= 1'b0;
            int_data <= 1'b0;
            int_sel <= 1'b0;
            int_latch <= 1'b0;
        end else begin
            case (state)
                scc_pkg::ST_IDLE: begin
                    // start a refresh only when this controller owns the chain
                    if (drv_s == scc_pkg::DRV_INT) begin
                        act_q <= act_s;
                        byte_q <= {in_s[7:1], first_design_input};
                        out_len <= CW'((NUM_DESIGNS - int'(act_s)) * scc_pkg::BYTE_W);
                        bit_cnt <= '0;
                        phase <= 1'b0;
                        int_sel <= 1'b0;
                        state <= scc_pkg::ST_SHIFT_IN;
                    end
                end
                scc_pkg::ST_SHIFT_IN: begin
                    // data set with clock low, clock high the next cycle
                    if (!phase) begin
                        int_clk <= 1'b0;
                        int_data <= bit_for(bit_cnt, act_q, byte_q);
                        phase <= 1'b1;
                    end else begin
                        int_clk <= 1'b1;
                        phase <= 1'b0;
                        if (bit_cnt == TOTAL_BITS - 1'b1) begin
                            ws_cnt <= '0;
                            state <= scc_pkg::ST_WAIT_LATCH;
                        end else begin
                            bit_cnt <= bit_cnt + 1'b1;
                        end
                    end
                end
                scc_pkg::ST_WAIT_LATCH: begin
                    // settle the chain before latching
                    int_clk <= 1'b0;
                    if (ws_cnt == wait_cnt) begin
                        ws_cnt <= '0;
                        int_latch <= 1'b1;
                        state <= scc_pkg::ST_LATCH;
                    end else begin
                        ws_cnt <= ws_cnt + 1'b1;
                    end
                end
                scc_pkg::ST_LATCH: begin
                    // latch held for the wait count plus one
                    if (ws_cnt == wait_cnt) begin
                        ws_cnt <= '0;
                        int_latch <= 1'b0;
                        int_sel <= 1'b1;
                        state <= scc_pkg::ST_WAIT_CAP;
                    end else begin
                        ws_cnt <= ws_cnt + 1'b1;
                    end
                end
                scc_pkg::ST_WAIT_CAP: begin
                    // select high and settled before the capture clock
                    if (ws_cnt == wait_cnt) begin
                        ws_cnt <= '0;
                        phase <= 1'b0;
                        state <= scc_pkg::ST_CAPTURE;
                    end else begin
                        ws_cnt <= ws_cnt + 1'b1;
                    end
                end
                scc_pkg::ST_CAPTURE: begin
                    // one clock pulse loads the design outputs
                    if (!phase) begin
                        int_clk <= 1'b1;
                        phase <= 1'b1;
                    end else begin
                        int_clk <= 1'b0;
                        int_sel <= 1'b0;
                        phase <= 1'b0;
                        bit_cnt <= '0;
                        state <= scc_pkg::ST_SHIFT_OUT;
                    end
                end
                scc_pkg::ST_SHIFT_OUT: begin
                    // shift until the active byte has left the chain end
                    int_data <= 1'b0;
                    if (!phase) begin
                        int_clk <= 1'b1;
                        phase <= 1'b1;
                    end else begin
                        int_clk <= 1'b0;
                        phase <= 1'b0;
                        if (bit_cnt == out_len - 1'b1) begin
                            ws_cnt <= '0;
                            state <= scc_pkg::ST_DONE;
                        end else begin
                            bit_cnt <= bit_cnt + 1'b1;
                        end
                    end
                end
                scc_pkg::ST_DONE: begin
                    // return clock stopped; hand the byte on once there is room
                    if (ws_cnt != wait_cnt) begin
                        ws_cnt <= ws_cnt + 1'b1;
                    end else if (fifo_in_ready) begin
                        state <= scc_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= scc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // refresh completion: one cycle pulse and output byte update
    assign fifo_in_valid = (state == scc_pkg::ST_DONE) && (ws_cnt == wait_cnt);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready <= 1'b0;
            design_outputs <= '0;
        end else begin
            ready <= fifo_in_valid && fifo_in_ready;
            if (fifo_in_valid && fifo_in_ready) begin
                design_outputs <= ret_shift;
            end
        end
    end

    // outgoing data reclocked on the falling edge for hold margin
    always_ff @(negedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_data_n <= 1'b0;
        end else begin
            int_data_n <= int_data;
        end
    end

    // returned bits shift on the clock that leaves the chain end; read when that clock is still
    always_ff @(posedge chain_ret_clk or negedge presetn) begin
        if (!presetn) begin
            ret_shift <= '0;
        end else begin
            ret_shift <= {ret_shift[6:0], chain_ret_data};
        end
    end

    // driver multiplexer; pin paths are pure routing
    always_comb begin
        case (drv_s)
            scc_pkg::DRV_INT: begin
                chain_clk = int_clk;
                chain_data = int_data_n;
                chain_select = int_sel;
                chain_latch_en = int_latch;
            end
            scc_pkg::DRV_LA: begin
                chain_clk = la_scan_clk;
                chain_data = la_scan_data;
                chain_select = la_scan_select;
                chain_latch_en = la_scan_latch_en;
            end
            default: begin
                chain_clk = ext_scan_clk_out;
                chain_data = ext_scan_data_out;
                chain_select = ext_scan_select;
                chain_latch_en = ext_scan_latch_en;
            end
        endcase
    end
    assign ext_scan_clk_in = chain_ret_clk;
    assign ext_scan_data_in = chain_ret_data;

    scc_fifo #(
        .WIDTH(scc_pkg::BYTE_W),
        .DEPTH(scc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(pclk),
        .rst_n(presetn),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(ret_shift),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // bus slave: zero wait, error on unmapped address
    assign setup = psel && !penable;
    assign acc = psel && penable;
    assign mapped = (paddr == scc_pkg::ADDR_STATUS) || (paddr == scc_pkg::ADDR_DIVIDER) ||
                    (paddr == scc_pkg::ADDR_WAIT) || (paddr == scc_pkg::ADDR_OUTDATA);
    assign pready = 1'b1;
    assign pslverr = acc && !mapped;
    assign fifo_pop = acc && !pwrite && (paddr == scc_pkg::ADDR_OUTDATA) && fifo_out_valid;

    // read data prepared in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (setup) begin
            prdata <= '0;
            case (paddr)
                scc_pkg::ADDR_STATUS: begin
                    prdata[scc_pkg::STAT_EMPTY] <= !fifo_out_valid;
                    prdata[scc_pkg::STAT_FULL] <= !fifo_in_ready;
                    prdata[scc_pkg::STAT_SLOW] <= slow_clk;
                    prdata[scc_pkg::STAT_DIVEN] <= div_s;
                    prdata[scc_pkg::STAT_DRV_LSB +: 2] <= drv_s;
                    prdata[scc_pkg::STAT_BUSY] <= (state != scc_pkg::ST_IDLE);
                end
                scc_pkg::ADDR_DIVIDER: prdata[7:0] <= factor;
                scc_pkg::ADDR_WAIT: prdata[7:0] <= wait_cnt;
                scc_pkg::ADDR_OUTDATA: prdata[7:0] <= fifo_out_valid ? fifo_out_data : 8'h00;
                default: prdata <= '0;
            endcase
        end
    end

    // checks
    a_ready_single: assert property (@(posedge pclk) disable iff (!presetn) ready |=> !ready)
        else $error("ready held longer than one cycle");
    a_factor_load: assert property (@(posedge pclk) disable iff (!presetn) div_edge |=> factor == $past(in_s))
        else $error("factor not taken on strobe edge");
    a_slow_gated: assert property (@(posedge pclk) disable iff (!presetn) !div_s |=> !slow_clk)
        else $error("slow clock runs without strobe");
    a_slow_refresh: assert property (@(posedge pclk) disable iff (!presetn) (!ready && div_s) |=> $stable(slow_clk))
        else $error("slow clock moved between refreshes");
    a_bit_period: assert property (@(posedge pclk) disable iff (!presetn)
        (state == scc_pkg::ST_SHIFT_IN && $rose(int_clk)) |=> !int_clk)
        else $error("shift clock high longer than one cycle");
    a_latch_wait: assert property (@(posedge pclk) disable iff (!presetn)
        (state == scc_pkg::ST_WAIT_LATCH && ws_cnt == wait_cnt) |=> int_latch && state == scc_pkg::ST_LATCH)
        else $error("latch not raised after wait");
    a_strap_take: assert property (@(posedge pclk) disable iff (!presetn)
        (strap_cnt == scc_pkg::STRAP_SAMPLE && drv_s == scc_pkg::DRV_STRAP) |=> wait_cnt == $past(in_s))
        else $error("strapped wait count not taken");
    a_ext_route: assert property (@(posedge pclk) disable iff (!presetn)
        (drv_s == scc_pkg::DRV_EXT) |-> chain_select == ext_scan_select && chain_latch_en == ext_scan_latch_en)
        else $error("external pins not routed");
    a_shift_select: assert property (@(posedge pclk) disable iff (!presetn)
        (state == scc_pkg::ST_SHIFT_IN || state == scc_pkg::ST_SHIFT_OUT) |-> !int_sel)
        else $error("select high while shifting");
endmodule // scc_top
`default_nettype wire

// ===== bench/scc_chain_model.sv
// behavioural scan chain of inverter designs standing behind the block
`default_nettype none
module scc_chain_model #(
    parameter int N = 2
) (
    input wire logic clk,
    input wire logic data,
    input wire logic sel,
    input wire logic latch,
    output logic ret_clk,
    output logic ret_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [8*N-1:0] sr = '0; // scan flops, far end at the top
    logic [8*N-1:0] held = '0; // inputs latched into the designs
    // the clock travels along the chain with the data
    assign ret_clk = clk;
    // shift new bits in, or load the inverted design outputs
    always @(posedge clk) sr <= sel ? ~held : {sr[8*N-2:0], data};
    // hand the chain contents to the designs
    always @(posedge latch) held <= sr;
    // outgoing bit is reclocked on the falling edge
    always @(negedge clk) ret_data <= sr[8*N-1];
endmodule // scc_chain_model
`default_nettype wire

// ===== bench/tb.sv
// self-checking bench for the slow clock and driver configuration block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, ready, slow_clk;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [1:0] driver_sel = 2'h0;
    logic set_clk_div = 0, first_design_input, err, s0;
    logic [8:0] active_select = 9'h001;
    logic [7:0] design_inputs = 8'h5A, design_outputs;
    logic [3:0] ext = '0, la = '0; // clk, data, select, latch of each source
    logic chain_clk, chain_data, chain_select, chain_latch_en, chain_ret_clk, chain_ret_data;
    logic ext_scan_clk_in, ext_scan_data_in;
    int miscompares = 0, n_tests = 0, cyc = 0, tg;
    scc_top #(.NUM_DESIGNS(2), .WAIT_DEFAULT(8'h02)) scc_top_inst (.pclk, .presetn, .paddr, .psel, .penable,
        .pwrite, .pwdata, .prdata, .pready, .pslverr, .driver_sel, .set_clk_div, .active_select, .design_inputs,
        .design_outputs, .ready, .slow_clk, .first_design_input, .ext_scan_clk_out(ext[3]),
        .ext_scan_data_out(ext[2]), .ext_scan_select(ext[1]), .ext_scan_latch_en(ext[0]), .ext_scan_clk_in,
        .ext_scan_data_in, .la_scan_clk(la[3]), .la_scan_data(la[2]), .la_scan_select(la[1]),
        .la_scan_latch_en(la[0]), .chain_clk, .chain_data, .chain_select, .chain_latch_en, .chain_ret_clk,
        .chain_ret_data);
    scc_chain_model #(.N(2)) scc_chain_model_inst (.clk(chain_clk), .data(chain_data), .sel(chain_select),
        .latch(chain_latch_en), .ret_clk(chain_ret_clk), .ret_data(chain_ret_data));
    always #20 pclk = ~pclk;
    // cut a hang short
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer, setup then access until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // wait for a refresh, then see the pulse gone
    task automatic refresh();
        do @(posedge pclk); while (ready !== 1'b1);
        #1 chk(ready, 0);
        apb(0, 12'h00C, 0);
    endtask
    task automatic end_sim();
        if (miscompares == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        repeat (4) @(posedge pclk);
        apb(0, 12'h000, 0);
        chk(rd, 32'h1);
        apb(0, 12'h004, 0);
        chk(rd, 32'h0);
        apb(0, 12'h008, 0);
        chk(rd, 32'h2);
        apb(1, 12'h010, 32'h5);
        chk(err, 1);
        // every source pattern on the external pins, then on the analyser pins
        for (int i = 0; i < 32; i++) begin
            driver_sel <= (i < 16) ? 2'h0 : 2'h2;
            {ext, la} <= (i < 16) ? {i[3:0], 4'h0} : {4'h0, i[3:0]};
            repeat (3) @(posedge pclk);
            chk({chain_clk, chain_data, chain_select, chain_latch_en}, i[3:0]);
            chk({ext_scan_clk_in, ext_scan_data_in}, {i[3], chain_ret_data});
        end
        {ext, la} <= '0;
        driver_sel <= 2'h1;
        refresh();
        chk(design_outputs, 8'hA5);
        chk(rd, 32'hA5);
        design_inputs <= 8'h01;
        set_clk_div <= 1;
        refresh();
        apb(0, 12'h004, 0);
        chk(rd, 32'h1);
        s0 = slow_clk;
        tg = 0;
        for (int i = 0; i < 4; i++) begin
            refresh();
            tg += (slow_clk !== s0);
            s0 = slow_clk;
            chk(first_design_input, slow_clk);
        end
        chk(tg, 2);
        set_clk_div <= 0;
        repeat (4) @(posedge pclk);
        chk(first_design_input, 1'b1);
        chk(slow_clk, 1'b0);
        // strap a wait count through a second reset
        presetn <= 0;
        driver_sel <= 2'h3;
        design_inputs <= 8'h07;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        repeat (4) @(posedge pclk);
        apb(0, 12'h008, 0);
        chk(rd, 32'h7);
        end_sim();
    end
endmodule // tb
`default_nettype wire
